// ==== verilog/dabe_breakpoint.sv ====
`timescale 1ns/1ps
// Address breakpoint logic for comparators 1 to 3 with the next-instruction break.
module dabe_breakpoint
    import dabe_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_reset,
    input  wire logic              i_link_clk,
    input  wire logic              i_link_reset,
    input  wire logic              i_link_wr,
    input  wire logic [7:0]        i_link_addr,
    input  wire logic [7:0]        i_link_wdata,
    input  wire logic [ADDR_W-1:0] i_cpu_addr,
    input  wire logic              i_addr_valid,
    input  wire logic              i_first_fetch,
    input  wire logic              i_instr_boundary,
    input  wire logic              i_adl_mode,
    input  wire logic [7:0]        i_memory_base_page,
    output logic                   o_cpu_halt,
    output logic                   o_next_instruction_break
);

    // Write held in the link domain until the core has taken it.
    dabe_wr_s          link_hold;
    // Flips once for every write accepted on the link side.
    logic              link_toggle;
    // Two-stage synchroniser of the toggle into the core domain.
    logic              tog_sync1;
    logic              tog_sync2;
    // Last toggle value already acted upon by the core.
    logic              tog_seen;
    // One-cycle pulse: a new write is ready in link_hold.
    logic              wr_pulse;
    // Break control register, write only from the host.
    logic [7:0]        breakpoint_control;
    logic [7:0]        next_control;
    // Match values of comparators 1 to 3, left undefined after reset.
    logic [ADDR_W-1:0] match_value [NUM_MATCH];
    // Address actually presented to all comparators.
    logic [ADDR_W-1:0] cmp_addr;
    // Hit of each comparator, bit 0 for comparator 1.
    logic [NUM_MATCH-1:0] hit;
    // Any enabled comparator matches this cycle.
    logic              any_hit;
    // Host writes the control register this cycle.
    logic              wr_control;
    // A halt is started at this boundary.
    logic              boundary_break;
    logic              next_halt;

    // The link clock may stop right after a write, so all later work is done on the core side.
    // Link side: capture the write and flip the toggle; data then stays put.
    always_ff @(posedge i_link_clk) begin
        if (i_link_reset) begin
            link_toggle <= 1'b0;
        end else if (i_link_wr) begin
            link_hold   <= '{addr: i_link_addr, data: i_link_wdata};
            link_toggle <= ~link_toggle;
        end
    end

    // Core side: bring the toggle across in two flip-flops.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            tog_sync1 <= 1'b0;
            tog_sync2 <= 1'b0;
            tog_seen  <= 1'b0;
        end else begin
            tog_sync1 <= link_toggle;
            tog_sync2 <= tog_sync1;
            tog_seen  <= tog_sync2;
        end
    end

    // A changed toggle means link_hold is stable and may be read.
    assign wr_pulse   = tog_sync2 ^ tog_seen;
    assign wr_control = wr_pulse && (link_hold.addr == OFF_CONTROL);

    // A match sets the break bit and wins over a clearing write in the same cycle.
    always_comb begin
        next_control = breakpoint_control;
        if (wr_control) begin
            next_control = link_hold.data;
        end
        if (any_hit) begin
            next_control[BIT_NEXT_BREAK] = 1'b1;
        end
    end

    // Control register; reset clears every enable and the break bit.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            breakpoint_control <= CONTROL_RESET;
        end else begin
            breakpoint_control <= next_control;
        end
    end

    // In compatibility mode the base page supplies the top address byte.
    assign cmp_addr = i_adl_mode ? i_cpu_addr
                                 : {i_memory_base_page, i_cpu_addr[15:0]};

    // One register group and one comparator per breakpoint.
    for (genvar g = 0; g < NUM_MATCH; g++) begin : g_match
        // Byte offset of this group's low byte.
        localparam logic [7:0] BASE = 8'(OFF_MATCH1_LOW + MATCH_STRIDE * g);
        // This write lands in this group.
        logic sel;
        assign sel = wr_pulse && (link_hold.addr[7:2] == BASE[7:2]);

        // Each byte register fills its own part of the 24-bit value.
        always_ff @(posedge i_core_clk) begin
            if (sel && link_hold.addr[1:0] == SEL_LOW) begin
                match_value[g][7:0] <= link_hold.data;
            end
            if (sel && link_hold.addr[1:0] == SEL_HIGH) begin
                match_value[g][15:8] <= link_hold.data;
            end
            if (sel && link_hold.addr[1:0] == SEL_UPPER) begin
                match_value[g][23:16] <= link_hold.data;
            end
        end

        // Only comparator 1 has the skip-low-byte option.
        dabe_addr_match #(
            .AW (ADDR_W)
        ) u_match (
            .i_addr     (cmp_addr),
            .i_value    (match_value[g]),
            .i_enable   (i_addr_valid && breakpoint_control[BIT_MATCH1_EN + g]),
            .i_skip_low ((g == 0) && breakpoint_control[BIT_SKIP_LOW1]),
            .o_hit      (hit[g])
        );
    end

    // Several hits fold into one request.
    assign any_hit = |hit;

    // A halt starts only at a boundary; a first-byte match stops there at once.
    assign boundary_break = i_instr_boundary
                          && (breakpoint_control[BIT_NEXT_BREAK]
                              || (any_hit && i_first_fetch));
    // The halt lasts while the break bit stays set.
    assign next_halt = boundary_break
                     || (o_cpu_halt && next_control[BIT_NEXT_BREAK]);

    // Registered outputs to the CPU and as status.
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_cpu_halt               <= 1'b0;
            o_next_instruction_break <= 1'b0;
        end else begin
            o_cpu_halt               <= next_halt;
            o_next_instruction_break <= next_control[BIT_NEXT_BREAK];
        end
    end

    // Checks, all in the core domain.
    // Byte address of the upper register of comparator 3, used by the load check.
    localparam logic [7:0] OFF_MATCH3_UPPER = 8'(OFF_MATCH1_LOW + 2 * MATCH_STRIDE + SEL_UPPER);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    // A hit seen by the comparators.
    sequence match_seen;
        any_hit;
    endsequence

    // The break bit held at a boundary.
    sequence armed_boundary;
        breakpoint_control[BIT_NEXT_BREAK] && i_instr_boundary;
    endsequence

    match3_enable_a: assert property (hit[2] == (breakpoint_control[6] && i_addr_valid
                                      && cmp_addr == match_value[2]))
        else $error("Comparator 3 hit disagrees with its enable.");
    match2_enable_a: assert property (!breakpoint_control[5] |-> !hit[1])
        else $error("Comparator 2 hit while disabled.");
    match1_enable_a: assert property (!breakpoint_control[4] |-> !hit[0])
        else $error("Comparator 1 hit while disabled.");
    skip_low_a: assert property (i_addr_valid && breakpoint_control[4]
                                 && breakpoint_control[2]
                                 && cmp_addr[23:8] == match_value[0][23:8] |-> hit[0])
        else $error("Skip-low compare missed a page hit.");
    halt_boundary_a: assert property ($rose(o_cpu_halt) |-> $past(i_instr_boundary))
        else $error("Halt began away from a boundary.");
    deferred_break_a: assert property (any_hit && !i_instr_boundary |=> !$rose(o_cpu_halt))
        else $error("Mid-instruction match halted at once.");
    break_raise_a: assert property (match_seen |=> o_next_instruction_break
                                    && breakpoint_control[BIT_NEXT_BREAK])
        else $error("Match did not set the break bit.");
    break_hold_a: assert property (breakpoint_control[7] && !wr_control
                                   |=> breakpoint_control[7])
        else $error("Break bit dropped without a host write.");
    next_halt_a: assert property (armed_boundary |=> o_cpu_halt)
        else $error("Armed boundary did not halt.");
    base_page_a: assert property (!i_adl_mode |-> cmp_addr[23:16] == i_memory_base_page)
        else $error("Base page not used in compatibility mode.");
    single_req_a: assert property ($countones(hit) > 1
                                   |=> o_next_instruction_break && breakpoint_control[7])
        else $error("Joint hit gave no single break.");

    // With comparator 2 enabled, an exact address hit is never missed.
    match2_hit_a: assert property (breakpoint_control[5] && i_addr_valid
                                   && cmp_addr == match_value[1] |-> hit[1])
        else $error("Comparator 2 missed an exact hit.");
    // Without the skip option, comparator 1 needs the low byte to match as well.
    match1_full_a: assert property (!breakpoint_control[2]
                                    && cmp_addr[7:0] != match_value[0][7:0] |-> !hit[0])
        else $error("Comparator 1 ignored its low byte.");
    // An upper-byte write to comparator 3 lands in the top of its match value.
    upper3_load_a: assert property (wr_pulse && link_hold.addr == OFF_MATCH3_UPPER
                                    |=> match_value[2][23:16] == $past(link_hold.data))
        else $error("Upper byte of comparator 3 not loaded.");
    // A clearing host write with no new hit lets the halt go on the next edge.
    release_a: assert property (o_cpu_halt && wr_control && !link_hold.data[7]
                                && !any_hit && !i_instr_boundary |=> !o_cpu_halt)
        else $error("Halt held after the break bit was cleared.");
    // Leaving reset, every enable, the break bit and the halt are clear.
    reset_clear_a: assert property ($fell(i_reset) |-> breakpoint_control == CONTROL_RESET
                                    && !o_cpu_halt && !o_next_instruction_break)
        else $error("Reset did not clear the control register.");

endmodule

// ==== verilog/dabe_pkg.sv ====
package dabe_pkg;

    // Width of the CPU address that the comparators see.
    localparam int unsigned ADDR_W         = 24;
    // Number of comparators handled by this block.
    localparam int unsigned NUM_MATCH      = 3;

    // Byte offsets of the debug registers on the serial debug unit link.
    localparam logic [7:0]  OFF_MATCH1_LOW = 8'h04;
    localparam logic [7:0]  OFF_CONTROL    = 8'h10;
    // Distance between the register groups of two comparators.
    localparam logic [7:0]  MATCH_STRIDE   = 8'h04;
    // Position of the low, high and upper byte within one group.
    localparam logic [1:0]  SEL_LOW        = 2'h0;
    localparam logic [1:0]  SEL_HIGH       = 2'h1;
    localparam logic [1:0]  SEL_UPPER      = 2'h2;

    // Field positions inside breakpoint_control.
    localparam int unsigned BIT_NEXT_BREAK = 7;
    localparam int unsigned BIT_MATCH1_EN  = 4;
    localparam int unsigned BIT_SKIP_LOW1  = 2;
    // Value of breakpoint_control after reset.
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;

    // One register write carried across from the link clock.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } dabe_wr_s;

endpackage

// ==== verilog/dabe_addr_match.sv ====
`timescale 1ns/1ps
// One address comparator with an optional low-byte mask.
module dabe_addr_match
    import dabe_pkg::*;
#(
    parameter int unsigned AW = ADDR_W
) (
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [AW-1:0] i_value,
    input  wire logic          i_enable,
    input  wire logic          i_skip_low,
    output logic               o_hit
);

    // Upper part always takes part in the compare.
    logic hit_upper;
    // Low byte matches, or is masked out by the skip option.
    logic hit_low;

    // The low byte drops out of the compare when skipping is asked for.
    assign hit_upper = (i_addr[AW-1:8] == i_value[AW-1:8]);
    assign hit_low   = i_skip_low || (i_addr[7:0] == i_value[7:0]);
    // A disabled comparator never reports a hit.
    assign o_hit     = i_enable && hit_upper && hit_low;

endmodule

// ==== dv/dabe_host_model.sv ====
`timescale 1ns/1ps
// Debug host model: drives the link clock only while it talks, and writes registers.
module dabe_host_model
    import dabe_pkg::*;
(
    output logic       o_link_clk,
    output logic       o_link_reset,
    output logic       o_link_wr,
    output logic [7:0] o_link_addr,
    output logic [7:0] o_link_wdata
);
    logic run; // The link clock toggles while this is high, and once more if it was left high.
    // Phase is offset from the core clock, and the clock always stops low.
    initial begin
        o_link_clk = 1'b0;
        #1.3;
        forever begin
            #80;
            if (run || o_link_clk) begin
                o_link_clk = ~o_link_clk;
            end
        end
    end
    // Link reset is held for two link edges, then the clock stops.
    initial begin
        run = 1'b1;
        o_link_reset = 1'b1;
        o_link_wr = 1'b0;
        o_link_addr = 8'h00;
        o_link_wdata = 8'h00;
        repeat (2) @(posedge o_link_clk);
        @(negedge o_link_clk);
        run = 1'b0;
        o_link_reset = 1'b0;
    end
    // One write; released lines show inverted values, and two idle cycles follow.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wait (!o_link_reset);
        run = 1'b1;
        @(negedge o_link_clk);
        o_link_wr = 1'b1;
        o_link_addr = a;
        o_link_wdata = d;
        @(posedge o_link_clk);
        @(negedge o_link_clk);
        o_link_wr = 1'b0;
        o_link_addr = ~a;
        o_link_wdata = ~d;
        repeat (2) @(negedge o_link_clk);
        run = 1'b0;
    endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
// Top of the bench: core clock, design, debug host and the scenarios.
module testbench
    import dabe_pkg::*;
;
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] cpu_addr;
    logic              valid, first, bnd, adl;
    logic [7:0]        page;
    wire               link_clk, link_rst, link_wr, halt, nbrk;
    wire  [7:0]        link_addr, link_wdata;
    int                num_errors = 0;
    int                tests_run = 0;
    // Core clock of 4 ns.
    always #2 clk = ~clk;
    dabe_breakpoint DUT (.i_core_clk(clk), .i_reset(rst), .i_link_clk(link_clk),
        .i_link_reset(link_rst), .i_link_wr(link_wr), .i_link_addr(link_addr),
        .i_link_wdata(link_wdata), .i_cpu_addr(cpu_addr), .i_addr_valid(valid),
        .i_first_fetch(first), .i_instr_boundary(bnd), .i_adl_mode(adl),
        .i_memory_base_page(page), .o_cpu_halt(halt), .o_next_instruction_break(nbrk));
    dabe_host_model host (.o_link_clk(link_clk), .o_link_reset(link_rst),
        .o_link_wr(link_wr), .o_link_addr(link_addr), .o_link_wdata(link_wdata));
    // Prints the verdict and ends the run.
    task automatic results;
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Compares halt and break flag with expectations.
    task automatic check(input logic h, input logic b);
        `CHK(halt, h)
        `CHK(nbrk, b)
    endtask
    // One CPU address cycle, then the address is released and settled.
    task automatic cpu(input logic [23:0] a, input logic f, input logic b);
        @(negedge clk);
        cpu_addr = a;
        valid = 1'b1;
        first = f;
        bnd = b;
        @(negedge clk);
        valid = 1'b0;
        first = 1'b0;
        bnd = 1'b0;
        cpu_addr = ~a;
        @(negedge clk);
    endtask
    // Loads the three bytes of comparator n.
    task automatic setval(input int n, input logic [23:0] v);
        host.wr(8'(4 * n), v[7:0]);
        host.wr(8'(4 * n + 1), v[15:8]);
        host.wr(8'(4 * n + 2), v[23:16]);
    endtask
    // Disabled, near miss, deferred hit, halt at boundary, release.
    task automatic t_match(input int n);
        logic [23:0] v;
        v = {8'(n), 16'h5aa5};
        setval(n, v);
        host.wr(8'h10, 8'h00);
        cpu(v, 1'b1, 1'b1);
        check(1'b0, 1'b0);
        host.wr(8'h10, 8'h08 << n);
        cpu(v ^ 24'h1, 1'b0, 1'b1);
        check(1'b0, 1'b0);
        cpu(v, 1'b0, 1'b0);
        check(1'b0, 1'b1);
        cpu(v + 24'h3, 1'b0, 1'b1);
        check(1'b1, 1'b1);
        host.wr(8'h10, 8'h08 << n);
        check(1'b0, 1'b0);
    endtask
    // Comparator 1 with the low byte skipped breaks anywhere in its page.
    task automatic t_skip_low;
        setval(1, 24'h123456);
        host.wr(8'h10, 8'h14);
        cpu(24'h1234ff, 1'b1, 1'b1);
        check(1'b1, 1'b1);
        host.wr(8'h10, 8'h14);
        cpu(24'h123556, 1'b1, 1'b1);
        check(1'b0, 1'b0);
    endtask
    // In compatibility mode the base page stands in for the top address byte.
    task automatic t_base_page;
        setval(2, 24'hc31234);
        host.wr(8'h10, 8'h20);
        @(negedge clk);
        adl = 1'b0;
        page = 8'hc3;
        cpu(24'h7e1234, 1'b1, 1'b1);
        check(1'b1, 1'b1);
        host.wr(8'h10, 8'h20);
        @(negedge clk);
        page = 8'hc4;
        cpu(24'hc31234, 1'b1, 1'b1);
        check(1'b0, 1'b0);
        @(negedge clk);
        adl = 1'b1;
    endtask
    // A break bit written by the host halts at the next boundary.
    task automatic t_force_break;
        host.wr(8'h10, 8'h80);
        check(1'b0, 1'b1);
        cpu(24'h000000, 1'b0, 1'b1);
        check(1'b1, 1'b1);
        host.wr(8'h10, 8'h00);
        check(1'b0, 1'b0);
    endtask
    // Two comparators hitting together give one break.
    task automatic t_double_match;
        setval(2, 24'hc31234);
        setval(3, 24'hc31234);
        host.wr(8'h10, 8'h60);
        cpu(24'hc31234, 1'b0, 1'b0);
        check(1'b0, 1'b1);
        cpu(24'h000001, 1'b0, 1'b1);
        check(1'b1, 1'b1);
        host.wr(8'h10, 8'h60);
        check(1'b0, 1'b0);
    endtask
    // Writes to unused addresses change neither match values nor control.
    task automatic t_refused;
        setval(1, 24'h0a0b0c);
        host.wr(8'h10, 8'h10);
        host.wr(8'h07, 8'hff);
        host.wr(8'h11, 8'hff);
        host.wr(8'h13, 8'hff);
        check(1'b0, 1'b0);
        cpu(24'h0a0b0c, 1'b1, 1'b1);
        check(1'b1, 1'b1);
        host.wr(8'h10, 8'h10);
        check(1'b0, 1'b0);
    endtask
    // Main sequence after a two-cycle reset.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cpu_addr = 24'h000000;
        {valid, first, bnd, adl} = 4'h1;
        page = 8'h00;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(1'b0, 1'b0);
        for (int n = 1; n <= 3; n++) begin
            t_match(n);
        end
        t_skip_low;
        t_base_page;
        t_force_break;
        t_double_match;
        t_refused;
        results();
    end
    // Watchdog well beyond the expected run of about 30 us.
    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule
